// ---- sfos_pkg.sv ----
`default_nettype none
package sfos_pkg;
    // register pointers seen by the serial front end
    localparam logic [7:0] PTR_OVERTEMP_OUT_N_STATUS = 8'h30;
    localparam logic [7:0] PTR_FAULT_STATUS = 8'h31;
    localparam logic [7:0] PTR_OVERTEMP_OUT_N_MASK   = 8'h32;
    localparam logic [7:0] PTR_THERM1_DATA  = 8'h33;
    localparam logic [7:0] PTR_THERM2_DATA  = 8'h34;
    localparam logic [7:0] PTR_THERM3_DATA  = 8'h35;

    // field positions in overtemp_status and the overtemp mask
    localparam int OT_REM1_BIT  = 0;
    localparam int OT_TH1_BIT   = 3;
    localparam int OT_TH2_BIT   = 4;
    localparam int OT_TH3_BIT   = 5;
    // field positions in diode_fault_status
    localparam int FLT_REM1_BIT = 1;
    localparam int FLT_REM2_BIT = 2;
    localparam int FLT_REM3_BIT = 3;

    localparam logic [7:0] OT_USED_MASK    = 8'h39;
    localparam logic [7:0] FLT_USED_MASK   = 8'h0e;
    localparam logic [7:0] STATUS_RESET    = 8'h00;
    localparam logic [7:0] OT_MASK_RESET   = 8'h00;

    // trip hysteresis in codes
    localparam logic [8:0] HYST_CODES = 9'h004;

    // thermistor scaling: 10-bit fraction of reference, 1 code = 0.5 % of reference
    localparam int         THERM_FRAC_W = 10;
    localparam logic [14:0] THERM_MULT  = 15'h0019;
    localparam int         THERM_SHIFT  = 7;

    // factory address variants, index chosen by the top parameter
    localparam logic [3:0][6:0] SLAVE_ADDRS = {7'h4e, 7'h4c, 7'h1c, 7'h1a};

    typedef enum logic [2:0] {
        CH_LOCAL = 3'b000,
        CH_REM1  = 3'b001,
        CH_REM2  = 3'b010,
        CH_REM3  = 3'b011,
        CH_TH1   = 3'b100,
        CH_TH2   = 3'b101,
        CH_TH3   = 3'b110
    } sfos_chan_e;
endpackage
`default_nettype wire

// ---- sfos_thresh_cmp.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfos_thresh_cmp (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       upd,
    input  wire logic [7:0] value,
    input  wire logic [7:0] limit,
    output var  logic       tripped
);
    import sfos_pkg::*;

    typedef struct packed {
        logic [7:0] val;
        logic       trip;
    } sfos_cmp_s;

    sfos_cmp_s st_r;
    sfos_cmp_s st_nxt;

    // the clear test runs every cycle so a raised limit releases without a new sample
    always_comb begin
        st_nxt = st_r;
        if (upd) begin
            st_nxt.val = value;
        end
        if (upd && (value > limit)) begin
            st_nxt.trip = 1'b1;
        end else if (({1'b0, st_nxt.val} + HYST_CODES) <= {1'b0, limit}) begin
            st_nxt.trip = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tripped = st_r.trip;
endmodule // sfos_thresh_cmp
`default_nettype wire

// ---- sfos_status_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfos_status_top #(
    parameter logic [1:0] ADDR_SEL = 2'h0
) (
    input  wire logic                                mclk,
    input  wire logic                                rst,
    input  wire logic [2:0]                          diode_anode_hi_in,
    input  wire logic [2:0]                          diode_open_in,
    input  wire logic                                meas_valid,
    input  wire logic [sfos_pkg::THERM_FRAC_W-1:0]   meas_raw,
    input  wire logic [7:0]                          limit_rem1,
    input  wire logic [7:0]                          limit_th1,
    input  wire logic [7:0]                          limit_th2,
    input  wire logic [7:0]                          limit_th3,
    input  wire logic                                addr_valid,
    input  wire logic [6:0]                          addr_in,
    input  wire logic                                rd_en,
    input  wire logic [7:0]                          rd_ptr,
    input  wire logic                                wr_en,
    input  wire logic [7:0]                          wr_ptr,
    input  wire logic [7:0]                          wr_data,
    output var  logic [7:0]                          rd_data,
    output var  logic [2:0]                          seq_chan,
    output var  logic                                addr_ack,
    output var  logic                                overtemp_out_n,
    output var  logic                                overtemp_oe
);
    import sfos_pkg::*;

    // all state but the comparators' in one record, registered in one place
    typedef struct packed {
        logic [2:0][2:0] anode_sync;
        logic [2:0][2:0] open_sync;
        logic [2:0]      fault;
        logic [7:0]      ot_mask;
        logic [2:0][7:0] therm_data;
        sfos_chan_e      seq;
        logic [7:0]      rd_data;
        logic            addr_ack;
        logic            overtemp_out_n_n;
        logic            overtemp_out_n_oe;
    } sfos_top_s;

    sfos_top_s  st_r;
    sfos_top_s  st_nxt;
    logic [3:0] trip;
    logic [3:0] cmp_upd;
    logic [3:0][7:0] cmp_limit;
    logic [7:0] conv_code;
    logic [7:0] ot_status;
    logic [7:0] flt_status;

    // 25/128 of a 1024-step fraction tops out at 199, so the code never wraps
    function automatic logic [7:0] therm_scale(input logic [THERM_FRAC_W-1:0] frac);
        logic [14:0] prod;

        prod = 15'(frac) * THERM_MULT;
        return prod[14:THERM_SHIFT];
    endfunction

    // only remote channels can be skipped
    function automatic logic chan_skipped(input sfos_chan_e c, input logic [2:0] flt);
        logic [1:0] idx;

        idx = 2'(c - CH_REM1);
        return (c >= CH_REM1) && (c <= CH_REM3) && flt[idx];
    endfunction

    // local and thermistor channels are never skipped, so four steps always land
    function automatic sfos_chan_e next_chan(input sfos_chan_e cur, input logic [2:0] flt);
        sfos_chan_e c;
        logic       done;

        c = cur;
        done = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (!done) begin
                c = (c == CH_TH3) ? CH_LOCAL : sfos_chan_e'(c + 3'h1);
                done = !chan_skipped(c, flt);
            end
        end
        return c;
    endfunction

    assign cmp_limit = {limit_th3, limit_th2, limit_th1, limit_rem1};
    // remote codes pass straight through, thermistor fractions are rescaled
    assign conv_code = (st_r.seq >= CH_TH1) ? therm_scale(meas_raw) : meas_raw[7:0];

    // a comparator only takes a sample converted on its own channel
    always_comb begin
        cmp_upd = 4'h0;
        if (meas_valid) begin
            case (st_r.seq)
                CH_REM1: cmp_upd[0] = 1'b1;
                CH_TH1:  cmp_upd[1] = 1'b1;
                CH_TH2:  cmp_upd[2] = 1'b1;
                CH_TH3:  cmp_upd[3] = 1'b1;
                default: cmp_upd = 4'h0;
            endcase
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_cmp
        sfos_thresh_cmp u_cmp (
            .mclk    (mclk),
            .rst     (rst),
            .upd     (cmp_upd[g]),
            .value   (conv_code),
            .limit   (cmp_limit[g]),
            .tripped (trip[g])
        );
    end

    // reserved positions are hard zeros
    always_comb begin
        ot_status = STATUS_RESET;
        ot_status[OT_REM1_BIT] = trip[0];
        ot_status[OT_TH1_BIT]  = trip[1];
        ot_status[OT_TH2_BIT]  = trip[2];
        ot_status[OT_TH3_BIT]  = trip[3];

        flt_status = STATUS_RESET;
        flt_status[FLT_REM1_BIT] = st_r.fault[0];
        flt_status[FLT_REM2_BIT] = st_r.fault[1];
        flt_status[FLT_REM3_BIT] = st_r.fault[2];
    end

    always_comb begin
        logic [7:0] ot_src;
        logic       s3;
        ot_src = 8'h00;
        s3 = 1'b0;
        st_nxt = st_r;

        // analog detector levels: three stages, a change counts once stages two and three agree
        st_nxt.anode_sync = {st_r.anode_sync[1:0], diode_anode_hi_in};
        st_nxt.open_sync  = {st_r.open_sync[1:0], diode_open_in};

        // a level that differs between stages two and three leaves the old fault standing
        for (int c = 0; c < 3; c++) begin
            s3 = st_r.anode_sync[2][c] | st_r.open_sync[2][c];
            if ((st_r.anode_sync[1][c] == st_r.anode_sync[2][c]) &&
                (st_r.open_sync[1][c] == st_r.open_sync[2][c])) begin
                st_nxt.fault[c] = s3;
            end
        end

        if (meas_valid) begin
            st_nxt.seq = next_chan(st_r.seq, st_nxt.fault);
            // the sample belongs to the channel selected at the pulse
            case (st_r.seq)
                CH_TH1:  st_nxt.therm_data[0] = conv_code;
                CH_TH2:  st_nxt.therm_data[1] = conv_code;
                CH_TH3:  st_nxt.therm_data[2] = conv_code;
                default: st_nxt.therm_data = st_r.therm_data;
            endcase
        end else if (chan_skipped(st_r.seq, st_r.fault)) begin
            // a channel that faults while selected is left at once
            st_nxt.seq = next_chan(st_r.seq, st_r.fault);
        end

        // reserved mask positions are forced to zero
        if (wr_en && (wr_ptr == PTR_OVERTEMP_OUT_N_MASK)) begin
            st_nxt.ot_mask = wr_data & OT_USED_MASK;
        end

        // a faulted remote 1 looks like an overtemp until it is masked
        ot_src = ot_status;
        ot_src[OT_REM1_BIT] = ot_status[OT_REM1_BIT] | st_r.fault[0];
        st_nxt.overtemp_out_n_n  = ~|(ot_src & ~st_r.ot_mask & OT_USED_MASK);
        // the open-drain enable is on exactly while the pin is pulled low
        st_nxt.overtemp_out_n_oe = ~st_nxt.overtemp_out_n_n;

        // the variant is a build-time choice, so no address pins are sampled
        st_nxt.addr_ack = addr_valid && (addr_in == SLAVE_ADDRS[ADDR_SEL]);

        // read data is captured once and held until the next read
        if (rd_en) begin
            case (rd_ptr)
                PTR_OVERTEMP_OUT_N_STATUS: st_nxt.rd_data = ot_status;
                PTR_FAULT_STATUS: st_nxt.rd_data = flt_status;
                PTR_OVERTEMP_OUT_N_MASK:   st_nxt.rd_data = st_r.ot_mask;
                PTR_THERM1_DATA:  st_nxt.rd_data = st_r.therm_data[0];
                PTR_THERM2_DATA:  st_nxt.rd_data = st_r.therm_data[1];
                PTR_THERM3_DATA:  st_nxt.rd_data = st_r.therm_data[2];
                default:          st_nxt.rd_data = 8'h00;
            endcase
        end
    end

    // mask and sequencer resets are spelled out though zero, to keep them visible
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_r          <= '0;
            st_r.ot_mask  <= OT_MASK_RESET;
            st_r.seq      <= CH_LOCAL;
            st_r.overtemp_out_n_n  <= 1'b1;
            st_r.overtemp_out_n_oe <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // every output is a flop of st_r
    assign rd_data        = st_r.rd_data;
    assign seq_chan       = st_r.seq;
    assign addr_ack       = st_r.addr_ack;
    assign overtemp_out_n = st_r.overtemp_out_n_n;
    assign overtemp_oe    = st_r.overtemp_out_n_oe;
endmodule // sfos_status_top
`default_nettype wire

// ---- sfos_status_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfos_status_props #(
    parameter logic [1:0] ADDR_SEL = 2'h0
) (
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic [2:0] diode_anode_hi_in,
    input wire logic [2:0] diode_open_in,
    input wire logic       addr_valid,
    input wire logic [6:0] addr_in,
    input wire logic       rd_en,
    input wire logic [7:0] rd_ptr,
    input wire logic [7:0] rd_data,
    input wire logic [2:0] seq_chan,
    input wire logic       addr_ack,
    input wire logic       overtemp_out_n
);
    import sfos_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ack_match_a: assert property (addr_valid && addr_in == SLAVE_ADDRS[ADDR_SEL]
        |=> addr_ack ##1 !addr_ack) else $error("address not acked");
    ack_other_a: assert property (addr_valid && addr_in != SLAVE_ADDRS[ADDR_SEL]
        |=> !addr_ack) else $error("foreign address acked");
    ot_rsv_a: assert property (rd_en && rd_ptr == PTR_OVERTEMP_OUT_N_STATUS
        |=> (rd_data & ~OT_USED_MASK) == 8'h00) else $error("overtemp reserved set");
    flt_rsv_a: assert property (rd_en && rd_ptr == PTR_FAULT_STATUS
        |=> (rd_data & ~FLT_USED_MASK) == 8'h00) else $error("fault reserved set");
    unmap_zero_a: assert property (rd_en && (rd_ptr < 8'h30 || rd_ptr > 8'h35)
        |=> rd_data == 8'h00) else $error("unmapped read not zero");
    rst_clear_a: assert property (disable iff (1'b0) rst
        |=> overtemp_out_n && !addr_ack && rd_data == 8'h00) else $error("reset state");
    rd_hold_a: assert property (!rd_en |=> $stable(rd_data))
        else $error("read data moved");
    fault_skip_a: assert property ((diode_open_in[0] || diode_anode_hi_in[0]) [*8]
        |-> seq_chan != CH_REM1) else $error("faulted channel selected");
    cover property (addr_ack);
    cover property (!overtemp_out_n);
    cover property (rd_en && rd_ptr == PTR_THERM1_DATA);
endmodule // sfos_status_props
bind sfos_status_top sfos_status_props #(.ADDR_SEL(ADDR_SEL)) i_sfos_status_props (
    .mclk(mclk), .rst(rst), .diode_anode_hi_in(diode_anode_hi_in),
    .diode_open_in(diode_open_in), .addr_valid(addr_valid), .addr_in(addr_in),
    .rd_en(rd_en), .rd_ptr(rd_ptr), .rd_data(rd_data), .seq_chan(seq_chan),
    .addr_ack(addr_ack), .overtemp_out_n(overtemp_out_n));
`default_nettype wire

// ---- sfos_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module sfos_host (
    input  wire logic       mclk,
    input  wire logic [7:0] rd_data,
    input  wire logic       addr_ack,
    output var  logic       rd_en,
    output var  logic [7:0] rd_ptr,
    output var  logic       wr_en,
    output var  logic [7:0] wr_ptr,
    output var  logic [7:0] wr_data,
    output var  logic       addr_valid,
    output var  logic [6:0] addr_in
);
    // released lines show the inverse so stale values never pass
    task automatic rd(input logic [7:0] p, output logic [7:0] d);
        @(posedge mclk) #1;
        rd_en = 1'b1;
        rd_ptr = p;
        @(posedge mclk) #1;
        d = rd_data;
        rd_en = 1'b0;
        rd_ptr = ~p;
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        @(posedge mclk) #1;
        wr_en = 1'b1;
        wr_ptr = p;
        wr_data = d;
        @(posedge mclk) #1;
        wr_en = 1'b0;
        wr_ptr = ~p;
        wr_data = ~d;
    endtask
    task automatic adr(input logic [6:0] a, output logic k);
        @(posedge mclk) #1;
        addr_valid = 1'b1;
        addr_in = a;
        @(posedge mclk) #1;
        k = addr_ack;
        addr_valid = 1'b0;
        addr_in = ~a;
    endtask
    initial begin
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr_valid = 1'b0;
        rd_ptr = 8'h00;
        wr_ptr = 8'h00;
        wr_data = 8'h00;
        addr_in = 7'h00;
    end
endmodule // sfos_host
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sfos_pkg::*;
    logic       mclk = 1'b0;
    logic       rst, mv, re, we, av, ack, otn, oe, k;
    logic [2:0] ahi, opn, sc;
    logic [9:0] raw;
    logic [7:0] lr1, lt1, lt2, lt3, rp, wp, wd, rdd, v;
    logic [6:0] ai;
    logic [6:0] adrs [5] = '{7'h1a, 7'h1c, 7'h4c, 7'h4e, 7'h1b};
    int         n_errors = 0;
    int         checks_done = 0;
    always #5 mclk = ~mclk;
    sfos_status_top i_sfos_status_top (.mclk(mclk), .rst(rst), .diode_anode_hi_in(ahi),
        .diode_open_in(opn), .meas_valid(mv), .meas_raw(raw), .limit_rem1(lr1),
        .limit_th1(lt1), .limit_th2(lt2), .limit_th3(lt3), .addr_valid(av),
        .addr_in(ai), .rd_en(re), .rd_ptr(rp), .wr_en(we), .wr_ptr(wp), .wr_data(wd),
        .rd_data(rdd), .seq_chan(sc), .addr_ack(ack), .overtemp_out_n(otn),
        .overtemp_oe(oe));
    sfos_host i_sfos_host (.mclk(mclk), .rd_data(rdd), .addr_ack(ack), .rd_en(re),
        .rd_ptr(rp), .wr_en(we), .wr_ptr(wp), .wr_data(wd), .addr_valid(av), .addr_in(ai));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [7:0] p, input logic [7:0] e);
        i_sfos_host.rd(p, v);
        chk($sformatf("reg %h", p), e, v);
    endtask
    // back-to-back pulses until the wanted channel has been converted
    task automatic meas(input logic [2:0] c, input logic [9:0] r);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 10 && !hit; i++) begin
            hit = (sc === c);
            raw = hit ? r : 10'h000;
            mv = 1'b1;
            @(posedge mclk) #1;
        end
        mv = 1'b0;
        chk("meas reached", 8'h01, {7'h00, hit});
    endtask
    task results;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        rst = 1'b1;
        {ahi, opn, mv, raw} = '0;
        lr1 = 8'h3c;
        lt1 = 8'h5a;
        {lt2, lt3} = 16'hffff;
        repeat (20) @(posedge mclk);
        #1 rst = 1'b0;
        for (logic [7:0] p = 8'h30; p < 8'h38; p++) rchk(p, 8'h00);
        rchk(8'h00, 8'h00);
        for (int j = 0; j < 5; j++) begin
            i_sfos_host.adr(adrs[j], k);
            chk("addr ack", 8'(j == 0), {7'h00, k});
        end
        meas(3'h1, 10'h050);
        meas(3'h4, 10'h200);
        rchk(PTR_THERM1_DATA, 8'h64);
        rchk(PTR_OVERTEMP_OUT_N_STATUS, 8'h09);
        chk("overtemp", 8'h00, {7'h00, otn});
        chk("overtemp oe", 8'h01, {7'h00, oe});
        i_sfos_host.wr(PTR_OVERTEMP_OUT_N_MASK, 8'hff);
        rchk(PTR_OVERTEMP_OUT_N_MASK, 8'h39);
        chk("overtemp", 8'h01, {7'h00, otn});
        chk("overtemp oe", 8'h00, {7'h00, oe});
        i_sfos_host.wr(PTR_OVERTEMP_OUT_N_MASK, 8'h00);
        lr1 = 8'h54;
        lt1 = 8'h68;
        rchk(PTR_OVERTEMP_OUT_N_STATUS, 8'h00);
        chk("overtemp", 8'h01, {7'h00, otn});
        chk("overtemp oe", 8'h00, {7'h00, oe});
        opn = 3'h6;
        ahi = 3'h1;
        repeat (6) @(posedge mclk);
        rchk(PTR_FAULT_STATUS, 8'h0e);
        chk("overtemp", 8'h00, {7'h00, otn});
        chk("overtemp oe", 8'h01, {7'h00, oe});
        // thermistor 2 and 3 limits sit below the held sample code of 0x64
        {lt2, lt3} = 16'h6060;
        mv = 1'b1;
        repeat (8) begin
            @(posedge mclk) #1;
            chk("seq remote", 8'h00, 8'(sc inside {3'h1, 3'h2, 3'h3}));
        end
        mv = 1'b0;
        rchk(PTR_OVERTEMP_OUT_N_STATUS, 8'h30);
        {lt2, lt3} = 16'h6868;
        rchk(PTR_OVERTEMP_OUT_N_STATUS, 8'h00);
        i_sfos_host.wr(PTR_OVERTEMP_OUT_N_MASK, 8'h01);
        rchk(PTR_OVERTEMP_OUT_N_MASK, 8'h01);
        chk("overtemp", 8'h01, {7'h00, otn});
        chk("overtemp oe", 8'h00, {7'h00, oe});
        {opn, ahi} = '0;
        repeat (8) @(posedge mclk);
        rchk(PTR_FAULT_STATUS, 8'h00);
        results();
    end
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
